// *** rtl/dcs_pkg.sv ***
package dcs_pkg;
   // Frame geometry
   localparam int FRAME_BITS = 24;
   localparam int BITCNT_W = 5;
   localparam logic [BITCNT_W-1:0] BITCNT_MAX = 5'h1f;
   localparam logic [BITCNT_W-1:0] BITCNT_FULL = 5'h18;
   // Number of high-side channels served here: 0 = eight, 1 = seven, 2 = six
   localparam int N_CH = 3;
   // Word select: bit 0 of the received word picks the second control word
   localparam logic SEL_CTRL1 = 1'b1;
   // Internal time base
   localparam int CLK_NS = 20;
   localparam int TICK_NS = 1000;
   localparam int TICK_CYC = TICK_NS / CLK_NS;
   localparam int DIV_W = 6;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYC - 1);
   // Settling time of the charge pump, in microseconds and ticks
   localparam int SETTLE_US = 64;
   localparam int TMR_W = 8;
   localparam logic [TMR_W-1:0] SETTLE_TICKS = TMR_W'((SETTLE_US * 1000) / TICK_NS);
   // Over-current retry off-times, selected by the duty-cycle bit
   localparam int REC_OFF_LONG_US = 200;
   localparam int REC_OFF_SHORT_US = 50;
   localparam logic [TMR_W-1:0] REC_LONG_TICKS = TMR_W'((REC_OFF_LONG_US * 1000) / TICK_NS);
   localparam logic [TMR_W-1:0] REC_SHORT_TICKS = TMR_W'((REC_OFF_SHORT_US * 1000) / TICK_NS);
   localparam logic [TMR_W-1:0] TMR_ZERO = 8'h00;

   // Second control word as received
   typedef struct packed {
      logic enable;         // Bit 23, active / standby
      logic rec_ch8;        // Bit 22, recovery enable channel eight
      logic spare21;        // Bit 21
      logic rec_ch7;        // Bit 20, recovery enable channel seven
      logic rec_ch6;        // Bit 19, recovery enable channel six
      logic spare18;        // Bit 18
      logic [17:1] low;     // Lower control bits, kept elsewhere
      logic sel;            // Bit 0, word select
   } dcs_ctrl1_t;

   // Second status word as returned
   typedef struct packed {
      logic marker;                 // Bit 23, always one
      logic supply_over;            // Bit 22
      logic supply_under;           // Bit 21
      logic thermal_shutdown_flag;  // Bit 20
      logic temp_warning_flag;      // Bit 19
      logic not_ready;              // Bit 18
      logic [17:1] low;             // Lower status bits, from elsewhere
      logic no_error;               // Bit 0
   } dcs_stat1_t;

   localparam dcs_ctrl1_t CTRL1_RST = 24'h000000;
endpackage

// *** rtl/dcs_serial.sv ***
`timescale 1ns/1ns
// Full-duplex 24-bit shifter: captures on rising clock, shifts out on falling
module dcs_serial
   import dcs_pkg::*;
(
   input wire logic ref_clk,                    // System clock
   input wire logic rst,                        // Synchronous reset
   input wire logic sclk,                       // Serial clock, sampled
   input wire logic cs_n,                       // Frame select, active low
   input wire logic mosi,                       // Serial data in
   input wire logic [FRAME_BITS-1:0] tx_word,   // Word to return
   output logic miso,                           // Serial data out
   output logic frame_done,                     // Pulse after a full frame
   output logic [FRAME_BITS-1:0] rx_word        // Received word
);
   logic sclk_q_ff, cs_q_ff, miso_ff, done_ff;  // Registered pins and outputs
   logic nxt_miso, nxt_done;
   logic [FRAME_BITS-1:0] rx_sh_ff, tx_sh_ff, rx_ff; // Shift registers and received word
   logic [FRAME_BITS-1:0] nxt_rx_sh, nxt_tx_sh, nxt_rx;
   logic [BITCNT_W-1:0] cnt_ff, nxt_cnt;        // Bits captured this frame

   // Next-state of the shifter
   always_comb begin
      nxt_miso = miso_ff;
      nxt_done = 1'b0;
      nxt_rx_sh = rx_sh_ff;
      nxt_tx_sh = tx_sh_ff;
      nxt_rx = rx_ff;
      nxt_cnt = cnt_ff;
      if (cs_q_ff && !cs_n) begin
         // Frame start: load the status word, first bit out at once
         nxt_tx_sh = tx_word;
         nxt_miso = tx_word[FRAME_BITS-1];
         nxt_cnt = '0;
      end else if (!cs_n) begin
         if (sclk && !sclk_q_ff) begin
            // Rising edge: capture
            nxt_rx_sh = {rx_sh_ff[FRAME_BITS-2:0], mosi};
            if (cnt_ff != BITCNT_MAX) begin
               nxt_cnt = cnt_ff + 5'h01;
            end
         end else if (!sclk && sclk_q_ff && cnt_ff != '0) begin
            // Falling edge: present next bit
            nxt_tx_sh = {tx_sh_ff[FRAME_BITS-2:0], 1'b0};
            nxt_miso = tx_sh_ff[FRAME_BITS-2];
         end
      end else if (!cs_q_ff) begin
         // Frame end: only an exact 24-bit frame counts
         if (cnt_ff == BITCNT_FULL) begin
            nxt_done = 1'b1;
            nxt_rx = rx_sh_ff;
         end
      end
   end

   // Registers of the shifter
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sclk_q_ff <= 1'b0;
         cs_q_ff <= 1'b1;
         miso_ff <= 1'b0;
         done_ff <= 1'b0;
         rx_sh_ff <= '0;
         tx_sh_ff <= '0;
         rx_ff <= '0;
         cnt_ff <= '0;
      end else begin
         sclk_q_ff <= sclk;
         cs_q_ff <= cs_n;
         miso_ff <= nxt_miso;
         done_ff <= nxt_done;
         rx_sh_ff <= nxt_rx_sh;
         tx_sh_ff <= nxt_tx_sh;
         rx_ff <= nxt_rx;
         cnt_ff <= nxt_cnt;
      end
   end

   assign miso = miso_ff;
   assign frame_done = done_ff;
   assign rx_word = rx_ff;
endmodule // dcs_serial

// *** rtl/dcs_ctrl_status.sv ***
`timescale 1ns/1ns
module dcs_ctrl_status
   import dcs_pkg::*;
(
   input wire logic ref_clk,                  // System clock, 50 MHz
   input wire logic rst,                      // Synchronous reset, active high
   input wire logic sclk,                     // Serial clock
   input wire logic cs_n,                     // Frame select, active low
   input wire logic mosi,                     // Serial data in
   output logic miso,                         // Serial data out
   input wire logic supply_over,              // Load supply over limit
   input wire logic supply_under,             // Load supply under limit
   input wire logic thermal_shutdown_evt,     // Junction over shutdown limit
   input wire logic temp_warning_evt,         // Junction over warning limit
   input wire logic [N_CH-1:0] overcurrent_evt, // Per-channel over-current
   input wire logic reg0_clear,               // Reset bit written in word 0
   input wire logic reg0_duty,                // Recovery duty-cycle bit
   input wire logic [N_CH-1:0] chan_request,  // Per-channel on request
   input wire logic [22:1] stat0_bits,        // Fault bits of status word 0
   input wire logic [17:1] stat1_low,         // Lower bits of status word 1
   output logic active_mode,                  // Device active
   output logic not_ready,                    // Charge pump settling
   output logic [N_CH-1:0] chan_drive,        // Per-channel driver gate
   output logic [N_CH-1:0] overcurrent_flag,  // Over-current status to word 0
   output logic [N_CH-1:0] recovery_enable    // Recovery enables held
);
   logic frame_done;                       // Full frame received
   logic [FRAME_BITS-1:0] rx_word;         // Received word
   dcs_ctrl1_t rx_ctrl;                    // Received word as fields
   dcs_stat1_t stat_w;                     // Status word to return
   logic wr_ctrl;                          // Write to the second control word
   dcs_ctrl1_t ctrl_ff, nxt_ctrl;          // Second control word
   logic ov_ff, uv_ff, tsd_ff, tw_ff;      // Sticky status flags
   logic nxt_ov, nxt_uv, nxt_tsd, nxt_tw;
   logic [TMR_W-1:0] settle_ff, nxt_settle; // Settling timer in ticks
   logic nr_ff, nxt_nr;                    // Not-ready flag
   logic [DIV_W-1:0] div_ff, nxt_div;      // Tick divider
   logic tick_ff, nxt_tick;                // One-cycle internal clock tick
   logic [N_CH-1:0] rec_en;                // Recovery enables by channel
   logic [N_CH-1:0] blocked;               // Channel held off by over-current
   logic [N_CH-1:0] oc_flag;               // Over-current flags by channel
   logic allow;                            // Global permission to drive
   logic [N_CH-1:0] drive_ff, nxt_drive;   // Driver gates

   assign rx_ctrl = dcs_ctrl1_t'(rx_word);
   assign wr_ctrl = frame_done && (rx_ctrl.sel == SEL_CTRL1);
   assign rec_en = {ctrl_ff.rec_ch6, ctrl_ff.rec_ch7, ctrl_ff.rec_ch8};

   // Serial frame engine; returns the status word in every frame
   dcs_serial u_serial (
      .ref_clk(ref_clk),
      .rst(rst),
      .sclk(sclk),
      .cs_n(cs_n),
      .mosi(mosi),
      .tx_word(stat_w),
      .miso(miso),
      .frame_done(frame_done),
      .rx_word(rx_word)
   );

   // Status word assembly
   always_comb begin
      stat_w.marker = 1'b1;
      stat_w.supply_over = ov_ff;
      stat_w.supply_under = uv_ff;
      stat_w.thermal_shutdown_flag = tsd_ff;
      stat_w.temp_warning_flag = tw_ff;
      stat_w.not_ready = nr_ff;
      stat_w.low = stat1_low;
      // High only when no fault in either word
      stat_w.no_error = ~(|stat0_bits | ov_ff | uv_ff | tsd_ff | tw_ff | nr_ff
                         | |stat1_low);
   end

   // Next values of control word, flags, timers and drivers
   always_comb begin
      nxt_ctrl = ctrl_ff;
      if (wr_ctrl) begin
         if (rx_ctrl.enable) begin
            nxt_ctrl = rx_ctrl;
         end else begin
            nxt_ctrl = CTRL1_RST;
         end
      end
      // Hardware sets win over the host clear
      nxt_ov = supply_over | (ov_ff & ~reg0_clear);
      nxt_uv = supply_under | (uv_ff & ~reg0_clear);
      nxt_tsd = thermal_shutdown_evt | (tsd_ff & ~reg0_clear);
      nxt_tw = temp_warning_evt | (tw_ff & ~reg0_clear);
      // Divider gives the internal clock tick
      nxt_tick = (div_ff == DIV_LAST);
      nxt_div = nxt_tick ? '0 : div_ff + 6'h01;
      // Settling timer, loaded on standby to active, counts ticks
      if (!nxt_ctrl.enable) begin
         nxt_settle = TMR_ZERO;
      end else if (!ctrl_ff.enable) begin
         nxt_settle = SETTLE_TICKS;
      end else if (tick_ff && settle_ff != TMR_ZERO) begin
         nxt_settle = settle_ff - 8'h01;
      end else begin
         nxt_settle = settle_ff;
      end
      nxt_nr = (nxt_settle != TMR_ZERO);
      // Drive only when active, settled, cool and supply in range
      allow = ctrl_ff.enable & ~nr_ff & ~tsd_ff & ~thermal_shutdown_evt
              & ~supply_over & ~supply_under;
      nxt_drive = chan_request & {N_CH{allow}} & ~blocked & ~overcurrent_evt;
   end

   // Registers of control word, flags, timers and drivers
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl_ff <= CTRL1_RST;
         ov_ff <= 1'b0;
         uv_ff <= 1'b0;
         tsd_ff <= 1'b0;
         tw_ff <= 1'b0;
         settle_ff <= TMR_ZERO;
         nr_ff <= 1'b0;
         div_ff <= '0;
         tick_ff <= 1'b0;
         drive_ff <= '0;
      end else begin
         ctrl_ff <= nxt_ctrl;
         ov_ff <= nxt_ov;
         uv_ff <= nxt_uv;
         tsd_ff <= nxt_tsd;
         tw_ff <= nxt_tw;
         settle_ff <= nxt_settle;
         nr_ff <= nxt_nr;
         div_ff <= nxt_div;
         tick_ff <= nxt_tick;
         drive_ff <= nxt_drive;
      end
   end

   // Per-channel over-current latch and retry timer
   for (genvar i = 0; i < N_CH; i++) begin : g_ch
      logic flag_ff, nxt_flag;           // Over-current status
      logic blk_ff, nxt_blk;             // Output held off
      logic retry_ff, nxt_retry;         // Retry granted at expiry
      logic [TMR_W-1:0] off_ff, nxt_off; // Off-time left in ticks

      // Next values for one channel
      always_comb begin
         nxt_flag = overcurrent_evt[i] | (flag_ff & ~reg0_clear);
         nxt_blk = blk_ff;
         nxt_retry = retry_ff;
         nxt_off = off_ff;
         if (overcurrent_evt[i]) begin
            nxt_blk = 1'b1;
            nxt_off = reg0_duty ? REC_SHORT_TICKS : REC_LONG_TICKS;
            // Event on the tick phase already commits one retry
            nxt_retry = rec_en[i] | tick_ff;
         end else if (reg0_clear) begin
            nxt_blk = 1'b0;
            nxt_off = TMR_ZERO;
         end else if (blk_ff && tick_ff) begin
            if (off_ff != TMR_ZERO) begin
               nxt_off = off_ff - 8'h01;
            end else if (retry_ff || rec_en[i]) begin
               nxt_blk = 1'b0;
               nxt_retry = 1'b0;
            end
         end
      end

      // Registers for one channel
      always_ff @(posedge ref_clk) begin
         if (rst) begin
            flag_ff <= 1'b0;
            blk_ff <= 1'b0;
            retry_ff <= 1'b0;
            off_ff <= TMR_ZERO;
         end else begin
            flag_ff <= nxt_flag;
            blk_ff <= nxt_blk;
            retry_ff <= nxt_retry;
            off_ff <= nxt_off;
         end
      end

      assign blocked[i] = blk_ff;
      assign oc_flag[i] = flag_ff;
   end

   assign active_mode = ctrl_ff.enable;
   assign not_ready = nr_ff;
   assign chan_drive = drive_ff;
   assign overcurrent_flag = oc_flag;
   assign recovery_enable = rec_en;

   a_enable_active: assert property (@(posedge ref_clk) disable iff (rst)
      wr_ctrl && rx_ctrl.enable |=> active_mode && (not_ready || $past(active_mode)))
      else $error("enable write did not enter active mode");
   a_standby_clear: assert property (@(posedge ref_clk) disable iff (rst)
      wr_ctrl && !rx_ctrl.enable |=> ctrl_ff == CTRL1_RST ##1 chan_drive == '0)
      else $error("standby write did not clear control bits");
   a_reset_standby: assert property (@(posedge ref_clk)
      $fell(rst) |-> !active_mode && chan_drive == '0)
      else $error("device not in standby after reset");
   a_marker_out: assert property (@(posedge ref_clk) disable iff (rst)
      $fell(cs_n) ##1 !cs_n |-> miso)
      else $error("first returned bit is not one");
   a_supply_off: assert property (@(posedge ref_clk) disable iff (rst)
      supply_over || supply_under |=> chan_drive == '0 && (ov_ff || uv_ff))
      else $error("outputs active during supply fault");
   a_oc_off: assert property (@(posedge ref_clk) disable iff (rst)
      overcurrent_evt[0] |=> overcurrent_flag[0] && !chan_drive[0] ##1 !chan_drive[0])
      else $error("over-current did not switch channel off");
   a_tsd_hold: assert property (@(posedge ref_clk) disable iff (rst)
      tsd_ff && !reg0_clear |=> tsd_ff && chan_drive == '0)
      else $error("outputs active during thermal shutdown");
   a_tw_hold: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(tw_ff) ##1 !reg0_clear [*2] |-> tw_ff)
      else $error("warning flag dropped without clear");
   a_settle_block: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(active_mode) |-> not_ready ##1 chan_drive == '0)
      else $error("outputs active while not ready");
   a_noerr_bit: assert property (@(posedge ref_clk) disable iff (rst)
      (ov_ff || tsd_ff || nr_ff || |stat0_bits) |-> !stat_w.no_error)
      else $error("no-error bit high with fault present");
endmodule // dcs_ctrl_status

// *** verification/dcs_host_model.sv ***
`timescale 1ns/1ns
// Host controller model: sends whole 24-bit frames, MSB first
module dcs_host_model
   import dcs_pkg::*;
(
   input wire logic ref_clk, // System clock
   input wire logic miso, // Serial data from the device
   output logic sclk, // Serial clock, still between frames
   output logic cs_n, // Frame select, active low
   output logic mosi, // Serial data to the device
   output logic link_bad // Last returned frame looked like a dead link
);
   // Idle levels at time zero
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
      link_bad = 1'b0;
   end
   // One full-duplex frame, two cycles per clock phase
   task automatic xfer(input logic [FRAME_BITS-1:0] tx, output logic [FRAME_BITS-1:0] rx);
      rx = '0;
      @(negedge ref_clk);
      cs_n = 1'b0;
      for (int i = FRAME_BITS - 1; i >= 0; i--) begin
         mosi = tx[i];
         repeat (2) @(negedge ref_clk);
         rx[i] = miso;
         sclk = 1'b1;
         repeat (2) @(negedge ref_clk);
         sclk = 1'b0;
      end
      repeat (2) @(negedge ref_clk);
      cs_n = 1'b1;
      // Released data line must not keep its last level
      mosi = ~mosi;
      // All-low or all-high frames mean a broken supply or link
      link_bad = (rx == '0) || (&rx);
      repeat (3) @(negedge ref_clk);
   endtask
endmodule // dcs_host_model

// *** verification/test_dcs_ctrl_status.sv ***
`timescale 1ns/1ns
// Self-checking bench for the second control and status word
module test_dcs_ctrl_status;
   import dcs_pkg::*;
   logic ref_clk; // 50 MHz clock
   logic rst; // Synchronous reset
   logic sclk, cs_n, mosi, miso, link_bad; // Serial link
   logic [3:0] flt; // Over, under, shutdown, warning
   logic [N_CH-1:0] oc_evt; // Over-current events
   logic reg0_clear; // Clear pulse from word 0
   logic reg0_duty; // Retry duty select
   logic [N_CH-1:0] chan_request; // Channel on requests
   logic [22:1] stat0_bits; // Status word 0 faults
   logic [17:1] stat1_low; // Lower status bits
   logic active_mode, not_ready; // Mode outputs
   logic [N_CH-1:0] chan_drive, overcurrent_flag, recovery_enable; // Channel outputs
   logic [23:0] rx; // Returned frame
   int failures, check_count, n; // Counters
   dcs_ctrl_status u_dut (.ref_clk(ref_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
      .mosi(mosi), .miso(miso), .supply_over(flt[3]), .supply_under(flt[2]),
      .thermal_shutdown_evt(flt[1]), .temp_warning_evt(flt[0]), .overcurrent_evt(oc_evt),
      .reg0_clear(reg0_clear), .reg0_duty(reg0_duty), .chan_request(chan_request),
      .stat0_bits(stat0_bits), .stat1_low(stat1_low), .active_mode(active_mode),
      .not_ready(not_ready), .chan_drive(chan_drive), .overcurrent_flag(overcurrent_flag),
      .recovery_enable(recovery_enable));
   dcs_host_model u_host (.ref_clk(ref_clk), .miso(miso), .sclk(sclk), .cs_n(cs_n),
      .mosi(mosi), .link_bad(link_bad));
   // Clock generator, 20 ns period
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   // Compare one value
   task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Compare an elapsed cycle count with a window
   task automatic chk_time(input string nm, input int lo, input int hi, input int got);
      check_count++;
      if (got < lo || got > hi) begin
         failures++;
         $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, got);
      end
   endtask
   // Send a frame and compare the returned status word
   task automatic frame(input logic [23:0] tx, input logic [23:0] exp);
      u_host.xfer(tx, rx);
      chk("status word", exp, rx);
      chk("link check", 24'h000000, {23'h0, link_bad});
   endtask
   // Bounded wait: 0 for settle end, 1 for channel eight back on
   task automatic wait_for(input int sel, input int lim, output int cnt);
      cnt = 0;
      while (!((sel == 0) ? (not_ready === 1'b0) : (chan_drive[0] === 1'b1))) begin
         @(negedge ref_clk);
         cnt++;
         if (cnt >= lim) begin
            failures++;
            $display("ERROR wait %0d expected done seen timeout", sel);
            finish_test();
         end
      end
   endtask
   // Pulse the clear bit of word 0
   task automatic clear_pulse();
      @(negedge ref_clk) reg0_clear = 1'b1;
      @(negedge ref_clk) reg0_clear = 1'b0;
      repeat (2) @(negedge ref_clk);
   endtask
   // Verdict and end of run
   task automatic finish_test();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      rst = 1'b1;
      flt = 4'h0;
      oc_evt = 3'h0;
      reg0_clear = 1'b0;
      reg0_duty = 1'b1;
      chan_request = 3'h7;
      stat0_bits = 22'h000000;
      stat1_low = 17'h00001;
      failures = 0;
      check_count = 0;
      repeat (20) @(negedge ref_clk);
      rst = 1'b0;
      chk("active after reset", 24'h000000, {23'h0, active_mode});
      chk("drive after reset", 24'h000000, {21'h0, chan_drive});
      frame(24'h000000, 24'h800002);
      stat1_low = 17'h00000;
      stat0_bits = 22'h200000;
      frame(24'h000000, 24'h800000);
      stat0_bits = 22'h000000;
      frame(24'h000000, 24'h800001);
      $display("test reset done");
      // Enable with all recovery bits, then settle
      frame(24'hd80001, 24'h800001);
      chk("active", 24'h000001, {23'h0, active_mode});
      chk("recovery", 24'h000007, {21'h0, recovery_enable});
      chk("drive settling", 24'h000000, {21'h0, chan_drive});
      frame(24'h000000, 24'h840000);
      wait_for(0, 3500, n);
      chk_time("settle time", 2850, 3250, n);
      repeat (3) @(negedge ref_clk);
      chk("drive ready", 24'h000007, {21'h0, chan_drive});
      $display("test enable done");
      // Supply, shutdown and warning faults in turn
      for (int k = 0; k < 4; k++) begin
         flt = 4'h8 >> k;
         repeat (3) @(negedge ref_clk);
         if (k < 3) chk("drive fault", 24'h000000, {21'h0, chan_drive});
         if (k >= 2) flt = 4'h0;
         repeat (40) @(negedge ref_clk);
         chk("drive held", (k < 3) ? 24'h0 : 24'h7, {21'h0, chan_drive});
         frame(24'h000000, 24'h800000 | (24'h400000 >> k));
         flt = 4'h0;
         repeat (3) @(negedge ref_clk);
         chk("drive back", (k == 2) ? 24'h0 : 24'h7, {21'h0, chan_drive});
         clear_pulse();
         chk("drive cleared", 24'h000007, {21'h0, chan_drive});
         frame(24'h000000, 24'h800001);
      end
      $display("test faults done");
      // Over-current on channel eight with short retry
      @(negedge ref_clk) oc_evt = 3'h1;
      @(negedge ref_clk) oc_evt = 3'h0;
      chk("oc flag", 24'h000001, {21'h0, overcurrent_flag});
      chk("oc drive", 24'h000006, {21'h0, chan_drive});
      wait_for(1, 3000, n);
      chk_time("retry time", 2400, 2600, n);
      clear_pulse();
      chk("oc cleared", 24'h000000, {21'h0, overcurrent_flag});
      // Same channel again with the long off-time
      reg0_duty = 1'b0;
      @(negedge ref_clk) oc_evt = 3'h1;
      @(negedge ref_clk) oc_evt = 3'h0;
      chk("oc flag long", 24'h000001, {21'h0, overcurrent_flag});
      wait_for(1, 11000, n);
      chk_time("retry long", 9900, 10200, n);
      clear_pulse();
      $display("test overcurrent done");
      // Disable: standby with every control bit cleared
      frame(24'h000001, 24'h800001);
      chk("standby", 24'h000000, {23'h0, active_mode});
      chk("recovery off", 24'h000000, {21'h0, recovery_enable});
      chk("drive off", 24'h000000, {21'h0, chan_drive});
      $display("test standby done");
      finish_test();
   end
endmodule // test_dcs_ctrl_status
